// >>> rtl/sdg_self_diag.v
// Self-diagnostics sequencer of the intelligent drive unit
// How it works
// - After reset release the hardware function test runs once by itself.
// - A power-up hardware fault makes the front LED blink.
// - Hardware test walks EPROM, processor periphery, working RAM, data buffer.
// - Seeks in two patterns, then checks read ID cylinder on track 0.
// - Write/read uses the repeating six-byte pattern, then all zeros.
// - Each pattern writes all maintenance blocks, then reads and compares.
// - Open jumper runs hardware, seek and write/read tests.
// - Offline run waits until executing and queued commands are done.
// - Offline loop repeats the three tests while no error is found.
// - During offline diagnostics the bus front end is told to stay silent.
// - The unit-offline bit chooses which set of tests runs.
// - Error-free online run ends with GOOD status.
// - Online error ends the command with CHECK CONDITION.
// - Online LED blink only for a hardware function test failure.
`timescale 1ns/100ps
`default_nettype none
`include "sdg_consts.vh"

module sdg_self_diag #(
  parameter CYL_W = 16,
  parameter CYL_MAX = 16'h03FF,
  parameter SEEK_STEPS = 8,
  parameter CE_BLOCKS = 16'h0008,
  parameter BLK_BYTES = 16'h0200,
  parameter BLINK_CYC = `SDG_BLINK_CYC
) (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire we_i,
  input wire re_i,
  output reg [31:0] rdata_o,
  output reg irq_o,
  // Diagnostic jumper and command queue
  input wire diag_jumper_terminal_a_i,
  input wire diag_jumper_terminal_b_i,
  input wire cmd_busy_i,
  output reg scsi_quiet_o,
  // Send diagnostic request and status
  input wire sd_valid_i,
  input wire sd_selftest_i,
  input wire sd_unitoffline_i,
  output reg status_valid_o,
  output reg status_check_o,
  // Hardware function test engine
  output reg hw_start_o,
  output reg [1:0] hw_item_o,
  input wire hw_done_i,
  input wire hw_fail_i,
  // Seek engine
  output reg seek_req_o,
  output reg [CYL_W-1:0] seek_cyl_o,
  input wire seek_done_i,
  input wire seek_fail_i,
  input wire [CYL_W-1:0] id_cyl_i,
  // Maintenance-area media port
  output reg media_wr_o,
  output reg media_rd_o,
  output reg [15:0] media_blk_o,
  output wire [7:0] wr_data_o,
  input wire media_ready_i,
  input wire rd_valid_i,
  input wire [7:0] rd_data_i,
  // Front panel
  output reg led_o
);

  // ==========================================================
  // States
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_WAITQ = 7'h02;
  localparam [6:0] S_HW = 7'h04;
  localparam [6:0] S_SEEK = 7'h08;
  localparam [6:0] S_WR = 7'h10;
  localparam [6:0] S_RD = 7'h20;
  localparam [6:0] S_END = 7'h40;

  reg [6:0] state_reg;
  reg [1:0] mode_reg;
  reg boot_reg;
  reg pend_reg;
  reg [15:0] step_reg;
  reg [15:0] byte_reg;
  reg pat_reg;
  reg fail_reg;
  reg fail_hw_reg;
  reg led_fault_reg;
  reg [1:0] ctrl_reg;
  reg [3:0] irq_stat_reg;
  reg [3:0] irq_mask_reg;
  reg [3:0] ev_reg;
  reg [15:0] loops_reg;
  reg [31:0] blink_reg;
  reg gen_restart;
  reg gen_step;
  reg gen_zero;
  wire [7:0] exp_byte;
  wire diag_sel;
  wire wr_take;
  wire rerun_wr;

  // Jumper open leaves both terminals pulled high
  // jumper selects mode
  assign diag_sel = diag_jumper_terminal_a_i & diag_jumper_terminal_b_i;
  assign wr_take = media_wr_o & media_ready_i;
  assign rerun_wr = we_i && (addr_i == `SDG_OFS_CTRL) && wdata_i[`SDG_CTRL_RERUN];

  // Seek target: two-point sweep first, then single-step sequential
  function [CYL_W-1:0] seek_target;
    input [15:0] step;
    begin
      if (step < SEEK_STEPS)
        seek_target = step[0] ? CYL_MAX[CYL_W-1:0] : {CYL_W{1'b0}};
      else
        seek_target = step[CYL_W-1:0] - SEEK_STEPS[CYL_W-1:0];
    end
  endfunction

  // ==========================================================
  // Pattern source
  sdg_pattern_gen u_pat (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .restart_i(gen_restart),
    .step_i(gen_step),
    .zero_sel_i(gen_zero),
    .byte_o(exp_byte)
  );
  assign wr_data_o = exp_byte;

  // Pattern restart, advance and zero select; zeros load as the first read pass ends
  always @* begin
    gen_restart = 1'b0;
    gen_step = 1'b0;
    gen_zero = pat_reg;
    if (state_reg == S_WR) begin
      gen_step = wr_take;
      gen_restart = wr_take && (byte_reg == BLK_BYTES - 16'h0001);
    end else if (state_reg == S_RD) begin
      gen_step = rd_valid_i;
      gen_restart = rd_valid_i && (byte_reg == BLK_BYTES - 16'h0001);
      gen_zero = pat_reg | (gen_restart && media_blk_o == CE_BLOCKS - 16'h0001);
    end else begin
      gen_restart = 1'b1;
    end
  end

  // ==========================================================
  // Test sequencer
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= S_IDLE;
      mode_reg <= `SDG_M_PWR;
      boot_reg <= 1'b1;
      pend_reg <= 1'b0;
      step_reg <= 16'h0000;
      byte_reg <= 16'h0000;
      pat_reg <= 1'b0;
      fail_reg <= 1'b0;
      fail_hw_reg <= 1'b0;
      led_fault_reg <= 1'b0;
      loops_reg <= 16'h0000;
      ev_reg <= 4'h0;
      scsi_quiet_o <= 1'b0;
      status_valid_o <= 1'b0;
      status_check_o <= 1'b0;
      hw_start_o <= 1'b0;
      hw_item_o <= 2'h0;
      seek_req_o <= 1'b0;
      seek_cyl_o <= {CYL_W{1'b0}};
      media_wr_o <= 1'b0;
      media_rd_o <= 1'b0;
      media_blk_o <= 16'h0000;
    end else begin
      hw_start_o <= 1'b0;
      seek_req_o <= 1'b0;
      status_valid_o <= 1'b0;
      ev_reg <= 4'h0;
      case (state_reg)
        S_IDLE: begin
          pend_reg <= 1'b0;
          hw_item_o <= 2'h0;
          step_reg <= 16'h0000;
          pat_reg <= 1'b0;
          if (boot_reg || rerun_wr) begin
            boot_reg <= 1'b0;
            mode_reg <= `SDG_M_PWR;
            fail_reg <= 1'b0;
            fail_hw_reg <= 1'b0;
            state_reg <= S_HW;
          end else if (diag_sel) begin
            mode_reg <= `SDG_M_OFF;
            state_reg <= S_WAITQ;
          end else if (sd_valid_i) begin
            if (sd_selftest_i) begin
              mode_reg <= sd_unitoffline_i ? `SDG_M_ON_FULL : `SDG_M_ON_HW;
              fail_reg <= 1'b0;
              fail_hw_reg <= 1'b0;
              led_fault_reg <= 1'b0;
              state_reg <= S_HW;
            end else begin
              status_valid_o <= 1'b1;
              status_check_o <= 1'b0;
              ev_reg[`SDG_EV_STATUS] <= 1'b1;
            end
          end
        end
        S_WAITQ: begin
          if (!diag_sel) begin
            state_reg <= S_IDLE;
          end else if (!cmd_busy_i) begin
            scsi_quiet_o <= 1'b1;
            fail_reg <= 1'b0;
            fail_hw_reg <= 1'b0;
            state_reg <= S_HW;
          end
        end
        S_HW: begin
          if (!pend_reg) begin
            hw_start_o <= 1'b1;
            pend_reg <= 1'b1;
          end else if (hw_done_i) begin
            pend_reg <= 1'b0;
            if (hw_fail_i) begin
              fail_reg <= 1'b1;
              fail_hw_reg <= 1'b1;
              state_reg <= S_END;
            end else if (hw_item_o == `SDG_HW_ITEMS) begin
              hw_item_o <= 2'h0;
              step_reg <= 16'h0000;
              if (mode_reg == `SDG_M_PWR || mode_reg == `SDG_M_ON_HW)
                state_reg <= S_END;
              else
                state_reg <= S_SEEK;
            end else begin
              hw_item_o <= hw_item_o + 2'h1;
            end
          end
        end
        S_SEEK: begin
          if (!pend_reg) begin
            seek_req_o <= 1'b1;
            seek_cyl_o <= seek_target(step_reg);
            pend_reg <= 1'b1;
          end else if (seek_done_i) begin
            pend_reg <= 1'b0;
            if (seek_fail_i || id_cyl_i != seek_cyl_o) begin
              fail_reg <= 1'b1;
              state_reg <= S_END;
            end else if (step_reg == 2 * SEEK_STEPS - 1) begin
              step_reg <= 16'h0000;
              byte_reg <= 16'h0000;
              media_blk_o <= 16'h0000;
              media_wr_o <= 1'b1;
              state_reg <= S_WR;
            end else begin
              step_reg <= step_reg + 16'h0001;
            end
          end
        end
        S_WR: begin
          if (wr_take) begin
            if (byte_reg == BLK_BYTES - 16'h0001) begin
              byte_reg <= 16'h0000;
              if (media_blk_o == CE_BLOCKS - 16'h0001) begin
                media_blk_o <= 16'h0000;
                media_wr_o <= 1'b0;
                media_rd_o <= 1'b1;
                state_reg <= S_RD;
              end else begin
                media_blk_o <= media_blk_o + 16'h0001;
              end
            end else begin
              byte_reg <= byte_reg + 16'h0001;
            end
          end
        end
        S_RD: begin
          if (rd_valid_i) begin
            if (rd_data_i != exp_byte) begin
              fail_reg <= 1'b1;
              media_rd_o <= 1'b0;
              state_reg <= S_END;
            end else if (byte_reg == BLK_BYTES - 16'h0001) begin
              byte_reg <= 16'h0000;
              if (media_blk_o == CE_BLOCKS - 16'h0001) begin
                media_blk_o <= 16'h0000;
                media_rd_o <= 1'b0;
                if (!pat_reg) begin
                  pat_reg <= 1'b1;
                  media_wr_o <= 1'b1;
                  state_reg <= S_WR;
                end else begin
                  state_reg <= S_END;
                end
              end else begin
                media_blk_o <= media_blk_o + 16'h0001;
              end
            end else begin
              byte_reg <= byte_reg + 16'h0001;
            end
          end
        end
        S_END: begin
          pat_reg <= 1'b0;
          hw_item_o <= 2'h0;
          step_reg <= 16'h0000;
          if (fail_hw_reg)
            led_fault_reg <= 1'b1;
          if (mode_reg == `SDG_M_OFF) begin
            if (!diag_sel) begin
              scsi_quiet_o <= 1'b0;
              state_reg <= S_IDLE;
            end else if (!fail_reg) begin
              loops_reg <= loops_reg + 16'h0001;
              ev_reg[`SDG_EV_LOOP] <= 1'b1;
              state_reg <= S_HW;
            end else if (!pend_reg) begin
              // Failure reported once, then the run rests here
              pend_reg <= 1'b1;
              ev_reg[`SDG_EV_FAIL] <= 1'b1;
            end
          end else begin
            if (mode_reg != `SDG_M_PWR) begin
              status_valid_o <= 1'b1;
              status_check_o <= fail_reg;
              ev_reg[`SDG_EV_STATUS] <= 1'b1;
            end
            ev_reg[`SDG_EV_PASS] <= ~fail_reg;
            ev_reg[`SDG_EV_FAIL] <= fail_reg;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers: control, sticky events and mask
  always @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_reg <= `SDG_CTRL_RST;
      irq_mask_reg <= `SDG_MASK_RST;
      irq_stat_reg <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      if (we_i && addr_i == `SDG_OFS_CTRL)
        ctrl_reg <= {1'b0, wdata_i[`SDG_CTRL_LED_EN]};
      if (we_i && addr_i == `SDG_OFS_IRQ_MASK)
        irq_mask_reg <= wdata_i[3:0];
      // New events win over a clear in the same cycle
      if (we_i && addr_i == `SDG_OFS_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~wdata_i[3:0]) | ev_reg;
      else
        irq_stat_reg <= irq_stat_reg | ev_reg;
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data, one cycle after the strobe, zero elsewhere
  always @(posedge clk_i) begin
    if (srst_i || !re_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      case (addr_i)
        `SDG_OFS_CTRL: rdata_o <= {30'h0000_0000, ctrl_reg};
        `SDG_OFS_STAT: rdata_o <= {16'h0000, mode_reg, 3'h0, led_fault_reg,
          fail_hw_reg, fail_reg, 1'b0, state_reg};
        `SDG_OFS_IRQ_STAT: rdata_o <= {28'h000_0000, irq_stat_reg};
        `SDG_OFS_IRQ_MASK: rdata_o <= {28'h000_0000, irq_mask_reg};
        `SDG_OFS_LOOPS: rdata_o <= {16'h0000, loops_reg};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // LED blink divider
  // blink on fault
  always @(posedge clk_i) begin
    if (srst_i || !led_fault_reg || !ctrl_reg[`SDG_CTRL_LED_EN]) begin
      blink_reg <= 32'h0000_0000;
      led_o <= 1'b0;
    end else if (blink_reg == BLINK_CYC - 1) begin
      blink_reg <= 32'h0000_0000;
      led_o <= ~led_o;
    end else begin
      blink_reg <= blink_reg + 32'h0000_0001;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/sdg_consts.vh
// Constants shared by the drive self-diagnostics sequencer
`ifndef SDG_CONSTS_VH
`define SDG_CONSTS_VH

// ==========================================================
// Register offsets (byte addresses)
`define SDG_OFS_CTRL 8'h00
`define SDG_OFS_STAT 8'h04
`define SDG_OFS_IRQ_STAT 8'h08
`define SDG_OFS_IRQ_MASK 8'h0C
`define SDG_OFS_LOOPS 8'h10

// ==========================================================
// Field positions
`define SDG_CTRL_LED_EN 0
`define SDG_CTRL_RERUN 1
`define SDG_EV_PASS 0
`define SDG_EV_FAIL 1
`define SDG_EV_STATUS 2
`define SDG_EV_LOOP 3

// ==========================================================
// Reset values
`define SDG_CTRL_RST 2'h1
`define SDG_MASK_RST 4'h0

// ==========================================================
// Run modes
`define SDG_M_PWR 2'h0
`define SDG_M_OFF 2'h1
`define SDG_M_ON_HW 2'h2
`define SDG_M_ON_FULL 2'h3

// ==========================================================
// Write/read test pattern, repeated byte by byte
`define SDG_PAT_LEN 3'h6
`define SDG_PAT0 8'hBB
`define SDG_PAT1 8'hBA
`define SDG_PAT2 8'h64
`define SDG_PAT3 8'h5A
`define SDG_PAT4 8'h27
`define SDG_PAT5 8'hBB
`define SDG_PAT_ZERO 8'h00

// ==========================================================
// Timing and last hardware test item
`define SDG_CLK_KHZ 10000
`define SDG_BLINK_MS 250
`define SDG_BLINK_CYC (`SDG_BLINK_MS * `SDG_CLK_KHZ)
`define SDG_HW_ITEMS 2'h3

`endif

// >>> rtl/sdg_pattern_gen.v
// Byte source for the maintenance-area write/read test patterns
`timescale 1ns/100ps
`default_nettype none
`include "sdg_consts.vh"

module sdg_pattern_gen (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Control
  input wire restart_i,
  input wire step_i,
  input wire zero_sel_i,
  // Current pattern byte
  output reg [7:0] byte_o
);

  reg [2:0] idx_reg;

  // Byte of the six-byte pattern at a given index
  function [7:0] pat_byte;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: pat_byte = `SDG_PAT0;
        3'h1: pat_byte = `SDG_PAT1;
        3'h2: pat_byte = `SDG_PAT2;
        3'h3: pat_byte = `SDG_PAT3;
        3'h4: pat_byte = `SDG_PAT4;
        default: pat_byte = `SDG_PAT5;
      endcase
    end
  endfunction

  // ==========================================================
  // Index and byte register
  // two patterns
  always @(posedge clk_i) begin
    if (srst_i || restart_i) begin
      idx_reg <= 3'h0;
      byte_o <= zero_sel_i ? `SDG_PAT_ZERO : pat_byte(3'h0);
    end else if (step_i) begin
      if (idx_reg == `SDG_PAT_LEN - 3'h1) begin
        idx_reg <= 3'h0;
        byte_o <= zero_sel_i ? `SDG_PAT_ZERO : pat_byte(3'h0);
      end else begin
        idx_reg <= idx_reg + 3'h1;
        byte_o <= zero_sel_i ? `SDG_PAT_ZERO : pat_byte(idx_reg + 3'h1);
      end
    end
  end

endmodule
`default_nettype wire

// >>> verif/sdg_diag_monitor.sv
// Port checker for the self-diagnostics sequencer
`timescale 1ns/100ps
`default_nettype none
module sdg_diag_monitor #(
  parameter CYL_W = 16,
  parameter CYL_MAX = 16'h03FF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Jumper, queue and status
  input wire logic diag_jumper_terminal_a_i,
  input wire logic diag_jumper_terminal_b_i,
  input wire logic cmd_busy_i,
  input wire logic scsi_quiet_o,
  input wire logic status_valid_o,
  // Engines
  input wire logic hw_start_o,
  input wire logic [1:0] hw_item_o,
  input wire logic hw_done_i,
  input wire logic hw_fail_i,
  input wire logic seek_req_o,
  input wire logic [CYL_W-1:0] seek_cyl_o,
  input wire logic media_wr_o,
  input wire logic media_rd_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [1:0] nxt_item_reg;
  // Item that must follow a passing hardware item
  always_ff @(posedge clk_i) begin
    if (hw_done_i) begin
      nxt_item_reg <= hw_item_o + 2'h1;
    end
  end
  sequence s_item_ok;
    hw_done_i && !hw_fail_i && hw_item_o != 2'h3;
  endsequence
  sequence s_next_item;
    hw_start_o && hw_item_o == nxt_item_reg;
  endsequence
  power_up_a: assert property ($fell(srst_i) |-> ##[1:3] (hw_start_o && hw_item_o == 2'h0))
    else $error("hardware test did not start after reset");
  hw_order_a: assert property (s_item_ok |-> ##[1:3] s_next_item)
    else $error("hardware items out of order");
  hw_stop_a: assert property ((hw_done_i && hw_fail_i) |=> !hw_start_o [*8])
    else $error("hardware test restarted after a failure");
  seek_range_a: assert property (seek_req_o |-> seek_cyl_o <= CYL_MAX)
    else $error("seek target beyond last cylinder");
  wr_rd_excl_a: assert property (!(media_wr_o && media_rd_o))
    else $error("write and read phases overlap");
  quiet_entry_a: assert property ($rose(scsi_quiet_o) |-> !$past(cmd_busy_i) && diag_jumper_terminal_a_i && diag_jumper_terminal_b_i)
    else $error("offline run entered with commands pending");
  quiet_silent_a: assert property (scsi_quiet_o |-> !status_valid_o)
    else $error("status posted during offline run");
  status_pulse_a: assert property (status_valid_o |=> !status_valid_o)
    else $error("status pulse longer than one cycle");
endmodule
bind sdg_self_diag sdg_diag_monitor #(.CYL_W(CYL_W), .CYL_MAX(CYL_MAX)) i_sdg_diag_monitor (
  .clk_i(clk_i), .srst_i(srst_i),
  .diag_jumper_terminal_a_i(diag_jumper_terminal_a_i),
  .diag_jumper_terminal_b_i(diag_jumper_terminal_b_i),
  .cmd_busy_i(cmd_busy_i), .scsi_quiet_o(scsi_quiet_o), .status_valid_o(status_valid_o),
  .hw_start_o(hw_start_o), .hw_item_o(hw_item_o), .hw_done_i(hw_done_i),
  .hw_fail_i(hw_fail_i), .seek_req_o(seek_req_o), .seek_cyl_o(seek_cyl_o),
  .media_wr_o(media_wr_o), .media_rd_o(media_rd_o)
);
`default_nettype wire

// >>> verif/sdg_engine_model.sv
// Behavioural hardware test, seek and maintenance media engines
`timescale 1ns/100ps
`default_nettype none
module sdg_engine_model #(
  parameter CYL_W = 16
) (
  // Clock and fault injection
  input wire logic clk_i,
  input wire logic hw_bad_i,
  input wire logic seek_bad_i,
  input wire logic media_bad_i,
  // Hardware test engine
  input wire logic hw_start_i,
  input wire logic [1:0] hw_item_i,
  output logic hw_done_o = 1'b0,
  output logic hw_fail_o = 1'b0,
  // Seek engine
  input wire logic seek_req_i,
  input wire logic [CYL_W-1:0] seek_cyl_i,
  output logic seek_done_o = 1'b0,
  output logic seek_fail_o = 1'b0,
  output logic [CYL_W-1:0] id_cyl_o = '0,
  // Media
  input wire logic media_wr_i,
  input wire logic media_rd_i,
  input wire logic [15:0] media_blk_i,
  input wire logic [7:0] wr_data_i,
  output logic media_ready_o = 1'b0,
  output logic rd_valid_o = 1'b0,
  output logic [7:0] rd_data_o = 8'h00,
  // Counts
  output int seek_cnt_o = 0,
  output int wr_cnt_o = 0,
  output int pat_err_o = 0
);
  localparam logic [47:0] PAT = 48'hBBBA_645A_27BB;
  logic [7:0] q[$];
  logic [CYL_W-1:0] cyl = '0;
  logic [15:0] last_blk = 16'h0000;
  logic in_wr = 1'b0;
  logic zero_ph = 1'b0;
  int hw_dly = 0;
  int sk_dly = 0;
  int pos = 0;
  logic [1:0] cyc = 2'h0;
  // Engines answer late; qualifiers toggle outside their strobes
  always @(posedge clk_i) begin
    cyc <= cyc + 2'h1;
    hw_done_o <= 1'b0;
    hw_fail_o <= ~hw_fail_o;
    seek_done_o <= 1'b0;
    seek_fail_o <= ~seek_fail_o;
    id_cyl_o <= ~id_cyl_o;
    rd_valid_o <= 1'b0;
    rd_data_o <= ~rd_data_o;
    media_ready_o <= cyc != 2'h3;
    if (hw_start_i) hw_dly <= 3;
    else if (hw_dly > 0) hw_dly <= hw_dly - 1;
    if (hw_dly == 1) begin
      hw_done_o <= 1'b1;
      hw_fail_o <= hw_bad_i && hw_item_i == 2'h2;
    end
    if (seek_req_i) begin
      sk_dly <= 2;
      cyl <= seek_cyl_i;
      seek_cnt_o <= seek_cnt_o + 1;
    end else if (sk_dly > 0) sk_dly <= sk_dly - 1;
    // ID of track 0 on the reached cylinder
    if (sk_dly == 1) begin
      seek_done_o <= 1'b1;
      seek_fail_o <= 1'b0;
      id_cyl_o <= cyl ^ {{(CYL_W-1){1'b0}}, seek_bad_i};
    end
    // bytes checked per block and kept for read back
    if (media_wr_i && media_ready_o) begin
      if (!in_wr) begin
        q.delete();
        zero_ph = wr_data_i == 8'h00;
      end
      if (!in_wr || media_blk_i != last_blk) pos = 0;
      if (wr_data_i !== (zero_ph ? 8'h00 : PAT[8*(5-pos%6) +: 8])) pat_err_o <= pat_err_o + 1;
      q.push_back(wr_data_i ^ {7'h00, media_bad_i});
      pos++;
      in_wr = 1'b1;
      last_blk = media_blk_i;
      wr_cnt_o <= wr_cnt_o + 1;
    end
    if (!media_wr_i) in_wr = 1'b0;
    if (media_rd_i && cyc[0] && q.size() > 0) begin
      rd_valid_o <= 1'b1;
      rd_data_o <= q.pop_front();
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Testbench for the self-diagnostics sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sdg_consts.vh"
module tb_top;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic we_i = 1'b0, re_i = 1'b0, jmp_a = 1'b0, jmp_b = 1'b0, cmd_busy_i = 1'b0;
  logic sd_valid_i = 1'b0, sd_st = 1'b0, sd_uo = 1'b0;
  logic hw_bad = 1'b0, seek_bad = 1'b0, media_bad = 1'b0, led_q = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o, scsi_quiet_o, status_valid_o, status_check_o, hw_start_o, seek_req_o;
  logic media_wr_o, media_rd_o, led_o, hw_done, hw_fail, seek_done, seek_fail;
  logic media_ready, rd_valid;
  logic [1:0] hw_item_o;
  logic [15:0] seek_cyl_o, id_cyl, media_blk_o;
  logic [7:0] wr_data_o, rd_data;
  int failures = 0, cmp_count = 0, st_cnt = 0, led_tg = 0, hw_cnt = 0;
  int seek_cnt, wr_cnt, pat_err;
  sdg_self_diag #(.CYL_W(16), .CYL_MAX(16'h0003), .SEEK_STEPS(2), .CE_BLOCKS(16'h0002),
    .BLK_BYTES(16'h0008), .BLINK_CYC(4)) i_sdg_self_diag (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o), .diag_jumper_terminal_a_i(jmp_a),
    .diag_jumper_terminal_b_i(jmp_b), .cmd_busy_i(cmd_busy_i), .scsi_quiet_o(scsi_quiet_o),
    .sd_valid_i(sd_valid_i), .sd_selftest_i(sd_st), .sd_unitoffline_i(sd_uo),
    .status_valid_o(status_valid_o), .status_check_o(status_check_o),
    .hw_start_o(hw_start_o), .hw_item_o(hw_item_o), .hw_done_i(hw_done), .hw_fail_i(hw_fail),
    .seek_req_o(seek_req_o), .seek_cyl_o(seek_cyl_o), .seek_done_i(seek_done),
    .seek_fail_i(seek_fail), .id_cyl_i(id_cyl), .media_wr_o(media_wr_o),
    .media_rd_o(media_rd_o), .media_blk_o(media_blk_o), .wr_data_o(wr_data_o),
    .media_ready_i(media_ready), .rd_valid_i(rd_valid), .rd_data_i(rd_data), .led_o(led_o));
  sdg_engine_model #(.CYL_W(16)) i_sdg_engine_model (
    .clk_i(clk_i), .hw_bad_i(hw_bad), .seek_bad_i(seek_bad), .media_bad_i(media_bad),
    .hw_start_i(hw_start_o), .hw_item_i(hw_item_o), .hw_done_o(hw_done), .hw_fail_o(hw_fail),
    .seek_req_i(seek_req_o), .seek_cyl_i(seek_cyl_o), .seek_done_o(seek_done),
    .seek_fail_o(seek_fail), .id_cyl_o(id_cyl), .media_wr_i(media_wr_o),
    .media_rd_i(media_rd_o), .media_blk_i(media_blk_o), .wr_data_i(wr_data_o),
    .media_ready_o(media_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .seek_cnt_o(seek_cnt), .wr_cnt_o(wr_cnt), .pat_err_o(pat_err));
  // Clock and event counters
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    led_q <= led_o;
    if (led_o !== led_q) led_tg++;
    if (status_valid_o === 1'b1) st_cnt++;
    if (hw_start_o === 1'b1) hw_cnt++;
  end
  task automatic test_done();
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    reg_rd(a, v);
    chk(n, e, v);
  endtask
  // Poll a register until the masked bits are nonzero or the count is reached
  task automatic poll(input logic [7:0] a, input logic [31:0] m, output logic [31:0] v);
    int n;
    n = 0;
    v = 32'h0000_0000;
    while ((v & m) == 32'h0000_0000 && n < 1000) begin
      reg_rd(a, v);
      n++;
    end
  endtask
  task automatic sd_run(input logic st, input logic uo, input logic ck);
    int n;
    @(posedge clk_i);
    sd_valid_i <= 1'b1;
    sd_st <= st;
    sd_uo <= uo;
    @(posedge clk_i);
    sd_valid_i <= 1'b0;
    n = 0;
    while (status_valid_o !== 1'b1 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    chk("status_valid", 32'h1, {31'h0, status_valid_o});
    chk("status_check", {31'h0, ck}, {31'h0, status_check_o});
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    test_done();
  end
  // Main sequence
  initial begin
    logic [31:0] v;
    int h, s, w, t;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    poll(`SDG_OFS_STAT, 32'h0000_0001, v);
    chk("powerup_items", 32'h4, hw_cnt);
    rd_chk("stat", `SDG_OFS_STAT, 32'h0000_0001);
    rd_chk("ctrl", `SDG_OFS_CTRL, 32'h0000_0001);
    rd_chk("unmapped", 8'h20, 32'h0000_0000);
    rd_chk("irq_stat", `SDG_OFS_IRQ_STAT, 32'h0000_0001);
    chk("irq_masked", 32'h0, {31'h0, irq_o});
    reg_wr(`SDG_OFS_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(negedge clk_i);
    chk("irq_on", 32'h1, {31'h0, irq_o});
    reg_wr(`SDG_OFS_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(negedge clk_i);
    chk("irq_off", 32'h0, {31'h0, irq_o});
    h = hw_cnt;
    s = seek_cnt;
    w = wr_cnt;
    sd_run(1'b0, 1'b0, 1'b0);
    chk("no_test", h, hw_cnt);
    sd_run(1'b1, 1'b0, 1'b0);
    chk("hw_only", h + 4, hw_cnt);
    chk("no_seek", s, seek_cnt);
    sd_run(1'b1, 1'b1, 1'b0);
    chk("seeks", s + 4, seek_cnt);
    chk("bytes", w + 32, wr_cnt);
    chk("pattern", 32'h0, pat_err);
    hw_bad <= 1'b1;
    sd_run(1'b1, 1'b0, 1'b1);
    hw_bad <= 1'b0;
    t = led_tg;
    repeat (20) @(posedge clk_i);
    chk("led_hw", 32'h1, {31'h0, (led_tg - t) >= 4});
    seek_bad <= 1'b1;
    sd_run(1'b1, 1'b1, 1'b1);
    seek_bad <= 1'b0;
    t = led_tg;
    repeat (20) @(posedge clk_i);
    chk("led_seek", t, led_tg);
    reg_wr(`SDG_OFS_IRQ_STAT, 32'h0000_000F);
    h = hw_cnt;
    t = st_cnt;
    jmp_a <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("one_pin", h, hw_cnt);
    cmd_busy_i <= 1'b1;
    jmp_b <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk("queue_wait", h, hw_cnt);
    cmd_busy_i <= 1'b0;
    sd_valid_i <= 1'b1;
    sd_st <= 1'b1;
    @(posedge clk_i);
    sd_valid_i <= 1'b0;
    poll(`SDG_OFS_LOOPS, 32'hFFFF_FFFE, v);
    chk("loops", 32'h2, v);
    chk("loop_hw", 32'h1, {31'h0, (hw_cnt - h) >= 8});
    chk("quiet_on", 32'h1, {31'h0, scsi_quiet_o});
    chk("no_reply", t, st_cnt);
    media_bad <= 1'b1;
    poll(`SDG_OFS_STAT, 32'h0000_0100, v);
    chk("off_fail", 32'h1, {31'h0, v[8]});
    rd_chk("irq_loop_fail", `SDG_OFS_IRQ_STAT, 32'h0000_000A);
    h = hw_cnt;
    repeat (40) @(posedge clk_i);
    chk("loop_stop", h, hw_cnt);
    media_bad <= 1'b0;
    jmp_a <= 1'b0;
    jmp_b <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("quiet_off", 32'h0, {31'h0, scsi_quiet_o});
    hw_bad <= 1'b1;
    srst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    t = led_tg;
    repeat (100) @(posedge clk_i);
    chk("led_powerup", 32'h1, {31'h0, (led_tg - t) >= 4});
    test_done();
  end
endmodule
`default_nettype wire
